// *** mcis_pkg.sv ***
/*
  Package for the instruction subset execution block: opcode encodings,
  field positions, widths and reset values.
  Assumes 14-bit instruction words and a 128-entry data register file.
*/
`default_nettype none
package mcis_pkg;
  localparam int INSN_W      = 14;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int PC_W        = 13;
  localparam int JUMP_W      = 11;
  // Field positions in the instruction word and the page latch
  localparam int DEST_BIT    = 7;
  localparam int PCH_LO_BIT  = 3;
  localparam int PCH_HI_BIT  = 4;
  // Upper opcode bits, six for register forms
  localparam logic [5:0] OP_DEC_SKIP  = 6'h0b;
  localparam logic [5:0] OP_INC_SKIP  = 6'h0f;
  localparam logic [5:0] OP_INC       = 6'h0a;
  localparam logic [5:0] OP_OR_REG    = 6'h04;
  localparam logic [2:0] OP_JUMP      = 3'h5;
  localparam logic [5:0] OP_OR_LIT    = 6'h38;
  // Reset values
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [INSN_W-1:0] NOP_WORD  = 14'h0000;
endpackage : mcis_pkg
`default_nettype wire

// *** mcis_alu.sv ***
/*
  Arithmetic unit for the subset: increment, decrement and OR.
  Assumes purely combinational use by the core on one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mcis_alu (
  input  wire logic [7:0] opnd_reg,
  input  wire logic [7:0] opnd_acc,
  input  wire logic [7:0] literal,
  input  wire logic [2:0] func_sel,
  output logic      [7:0] result,
  output logic            result_zero
);
  // Function select: 0 inc, 1 dec, 2 or-reg, 3 or-literal
  wire logic [7:0] inc_val = opnd_reg + 8'h01;
  wire logic [7:0] dec_val = opnd_reg - 8'h01;
  wire logic [7:0] orr_val = opnd_acc | opnd_reg;
  wire logic [7:0] orl_val = opnd_acc | literal;
  assign result = (func_sel == 3'h1) ? dec_val :
                  (func_sel == 3'h2) ? orr_val :
                  (func_sel == 3'h3) ? orl_val : inc_val;
  assign result_zero = (result == 8'h00);  // RULE10
endmodule : mcis_alu
`default_nettype wire

// *** mcis_core.sv ***
/*
  Execution core for an instruction subset of an 8-bit controller.
  Assumes program memory returns the word at fetch_addr combinationally
  and the register file read is combinational with a synchronous write.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1 - Decrement-skip subtracts one, writes chosen destination, flags untouched.
// RULE2 - Zero decrement result turns the next instruction into a no-operation.
// RULE3 - Increment-skip adds one, flags untouched, zero result skips next.
// RULE4 - Register address 0..127; destination 0 is accumulator, 1 is register.
// RULE5 - Jump loads 11-bit operand into counter bits 10..0, takes two cycles.
// RULE6 - Jump copies latch bits 4..3 into counter bits 12..11.
// RULE7 - OR literal into accumulator, store in accumulator, update zero flag.
// RULE8 - Increment register to destination, update zero flag, never skip.
// RULE9 - OR accumulator with register to destination, update zero flag.
// RULE10 - Zero flag set when 8-bit result is zero, cleared otherwise.
module mcis_core (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [13:0] insn_word,
  input  wire logic [7:0]  rf_rd_data,
  input  wire logic [7:0]  pc_high_latch,
  output logic      [12:0] fetch_addr,
  output logic      [6:0]  rf_addr,
  output logic             rf_wr_en,
  output logic      [7:0]  rf_wr_data,
  output logic      [7:0]  acc_out,
  output logic             zero_flag_out,
  output logic             flush_out
);
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic        zero_reg;
  logic        zero_next;
  logic        flush_reg;
  logic        flush_next;
  logic        hold_reg;
  logic        hold_next;

  // Opcode decode; a flushed slot executes as a no-operation
  wire logic [13:0] exec_word = flush_reg ? mcis_pkg::NOP_WORD : insn_word;
  wire logic [5:0]  op6       = exec_word[13:8];
  wire logic        is_dec_s  = (op6 == mcis_pkg::OP_DEC_SKIP);
  wire logic        is_inc_s  = (op6 == mcis_pkg::OP_INC_SKIP);
  wire logic        is_inc    = (op6 == mcis_pkg::OP_INC);
  wire logic        is_or_r   = (op6 == mcis_pkg::OP_OR_REG);
  wire logic        is_or_l   = (op6 == mcis_pkg::OP_OR_LIT);
  wire logic        is_jump   = (exec_word[13:11] == mcis_pkg::OP_JUMP);
  wire logic        dest_reg  = exec_word[mcis_pkg::DEST_BIT];
  wire logic        reg_op    = is_dec_s | is_inc_s | is_inc | is_or_r;

  // Function select for the arithmetic unit
  wire logic [2:0] func_sel = is_dec_s ? 3'h1 :
                              is_or_r  ? 3'h2 :
                              is_or_l  ? 3'h3 : 3'h0;
  logic [7:0] alu_result;
  logic       alu_zero;

  mcis_alu u_alu (
    .opnd_reg    (rf_rd_data),
    .opnd_acc    (acc_reg),
    .literal     (exec_word[7:0]),
    .func_sel    (func_sel),
    .result      (alu_result),
    .result_zero (alu_zero)
  );

  // Register address and write back
  assign rf_addr    = exec_word[6:0];                 // RULE4
  // No write while reset holds the core, the slot is not executed then
  assign rf_wr_en   = reg_op & dest_reg & ~rst;       // RULE4
  assign rf_wr_data = alu_result;

  // Accumulator destination
  assign acc_next = (reg_op & ~dest_reg) | is_or_l ? alu_result : acc_reg;  // RULE1 RULE7 RULE9

  // Zero flag only for flag-affecting instructions
  assign zero_next = (is_inc | is_or_r | is_or_l) ? alu_zero : zero_reg;  // RULE8 RULE9 RULE10

  // Skip and jump both flush the following slot
  wire logic skip = (is_dec_s | is_inc_s) & alu_zero;  // RULE2 RULE3
  assign flush_next = skip | is_jump;                  // RULE5

  // Jump target from operand and page latch
  wire logic [12:0] jump_tgt = {pc_high_latch[mcis_pkg::PCH_HI_BIT:mcis_pkg::PCH_LO_BIT],
                                exec_word[10:0]};      // RULE5 RULE6

  // Bubble after a jump keeps the counter on the target, so the target runs next
  assign hold_next = is_jump;                                    // RULE5
  assign pc_next   = is_jump  ? jump_tgt :
                     hold_reg ? pc_reg   : pc_reg + 13'h0001;    // RULE5

  // Core state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_reg    <= mcis_pkg::PC_RESET;
      acc_reg   <= mcis_pkg::ACC_RESET;
      zero_reg  <= 1'b0;
      flush_reg <= 1'b0;
      hold_reg  <= 1'b0;
    end else begin
      pc_reg    <= pc_next;
      acc_reg   <= acc_next;
      zero_reg  <= zero_next;
      flush_reg <= flush_next;
      hold_reg  <= hold_next;
    end
  end

  assign fetch_addr    = pc_reg;
  assign acc_out       = acc_reg;
  assign zero_flag_out = zero_reg;
  assign flush_out     = flush_reg;

  // Assertions
  property p_dec_value;
    @(posedge clk_sys) disable iff (rst)
      is_dec_s && !dest_reg |=> acc_reg == $past(rf_rd_data) - 8'h01;
  endproperty
  a_dec_value: assert property (p_dec_value) else $error("decrement result wrong");  // RULE1

  property p_skip_flush;
    @(posedge clk_sys) disable iff (rst)
      (is_dec_s || is_inc_s) && alu_result == 8'h00 |=> flush_reg && !rf_wr_en;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("zero result did not skip");  // RULE2

  property p_skip_flags;
    @(posedge clk_sys) disable iff (rst)
      is_inc_s || is_dec_s |=> $stable(zero_reg);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip op changed zero flag");  // RULE3

  property p_dest_reg;
    @(posedge clk_sys) disable iff (rst)
      reg_op && dest_reg |-> rf_wr_en ##1 $stable(acc_reg);
  endproperty
  a_dest_reg: assert property (p_dest_reg) else $error("register destination wrong");  // RULE4

  property p_jump_low;
    @(posedge clk_sys) disable iff (rst)
      is_jump |=> flush_reg && pc_reg[10:0] == $past(exec_word[10:0]) ##1 !flush_reg && pc_reg == $past(pc_reg);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low bits or timing wrong");  // RULE5

  property p_jump_high;
    @(posedge clk_sys) disable iff (rst)
      is_jump |=> pc_reg[12:11] == $past(pc_high_latch[4:3]);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump page bits wrong");  // RULE6

  property p_or_lit;
    @(posedge clk_sys) disable iff (rst)
      is_or_l |=> acc_reg == ($past(acc_reg) | $past(exec_word[7:0])) && zero_reg == (acc_reg == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");  // RULE7

  property p_inc_noskip;
    @(posedge clk_sys) disable iff (rst)
      is_inc |=> !flush_reg && zero_reg == ($past(rf_rd_data) == 8'hff);
  endproperty
  a_inc_noskip: assert property (p_inc_noskip) else $error("increment flag or skip wrong");  // RULE8

  property p_or_reg;
    @(posedge clk_sys) disable iff (rst)
      is_or_r && !dest_reg |=> acc_reg == ($past(acc_reg) | $past(rf_rd_data));
  endproperty
  a_or_reg: assert property (p_or_reg) else $error("register OR wrong");  // RULE9

  property p_zero_flag;
    @(posedge clk_sys) disable iff (rst)
      is_or_r |=> zero_reg == ($past(acc_reg | rf_rd_data) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");  // RULE10

  property p_dec_reg_write;
    @(posedge clk_sys) disable iff (rst)
      is_dec_s && dest_reg |-> rf_wr_en && rf_wr_data == rf_rd_data - 8'h01;
  endproperty
  a_dec_reg_write: assert property (p_dec_reg_write) else $error("decrement write-back wrong");  // RULE1

  property p_dec_noskip;
    @(posedge clk_sys) disable iff (rst)
      is_dec_s && rf_rd_data != 8'h01 |=> !flush_reg;
  endproperty
  a_dec_noskip: assert property (p_dec_noskip) else $error("nonzero decrement skipped");  // RULE2

  property p_inc_skip_value;
    @(posedge clk_sys) disable iff (rst)
      is_inc_s |-> rf_wr_data == rf_rd_data + 8'h01 ##1 flush_reg == $past(rf_rd_data == 8'hff);
  endproperty
  a_inc_skip_value: assert property (p_inc_skip_value) else $error("increment-skip value or skip wrong");  // RULE3

  property p_dest_acc;
    @(posedge clk_sys) disable iff (rst)
      reg_op && !dest_reg |-> !rf_wr_en;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrote register");  // RULE4

  property p_jump_quiet;
    @(posedge clk_sys) disable iff (rst)
      is_jump |=> !rf_wr_en && $stable(acc_reg) && $stable(zero_reg);
  endproperty
  a_jump_quiet: assert property (p_jump_quiet) else $error("jump bubble changed state");  // RULE5

  property p_inc_reg_value;
    @(posedge clk_sys) disable iff (rst)
      is_inc && dest_reg |-> rf_wr_en && rf_wr_data == rf_rd_data + 8'h01;
  endproperty
  a_inc_reg_value: assert property (p_inc_reg_value) else $error("increment write-back wrong");  // RULE8

  property p_or_reg_write;
    @(posedge clk_sys) disable iff (rst)
      is_or_r && dest_reg |-> rf_wr_en && rf_wr_data == (acc_reg | rf_rd_data) ##1 $stable(acc_reg);
  endproperty
  a_or_reg_write: assert property (p_or_reg_write) else $error("register OR write-back wrong");  // RULE9

  property p_zero_keep;
    @(posedge clk_sys) disable iff (rst)
      !(is_inc || is_or_r || is_or_l) |=> $stable(zero_reg);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero flag changed by non-flag op");  // RULE10
endmodule : mcis_core
`default_nettype wire

// *** mcis_mem_model.sv ***
/*
  Partner model: program memory and data register file for the core.
  Assumes the core reads both combinationally and writes at the clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module mcis_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [12:0] fetch_addr,
  input  wire logic [6:0]  rf_addr,
  input  wire logic        rf_wr_en,
  input  wire logic [7:0]  rf_wr_data,
  output logic      [13:0] insn_word,
  output logic      [7:0]  rf_rd_data
);
  logic [13:0] prog [0:8191];
  logic [7:0]  regs [0:127];
  // Combinational reads
  assign insn_word  = prog[fetch_addr];
  assign rf_rd_data = regs[rf_addr];
  // Register write on the strobe; bench preloads too
  always @(posedge clk_sys) begin
    if (rf_wr_en) begin
      regs[rf_addr] <= rf_wr_data;
    end
  end
endmodule : mcis_mem_model
`default_nettype wire

// *** tb_mcu_core_insn_subset.sv ***
/*
  Bench for the instruction subset core with a memory partner model.
  Assumes one 20 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_core_insn_subset;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  pc_high_latch;
  wire  [13:0] insn_word;
  wire  [7:0]  rf_rd_data;
  wire  [12:0] fetch_addr;
  wire  [6:0]  rf_addr;
  wire         rf_wr_en;
  wire  [7:0]  rf_wr_data;
  wire  [7:0]  acc_out;
  wire         zero_flag_out;
  wire         flush_out;
  int          n_errors;
  int          num_checks;
  // Clock and design under test
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  mcis_core dut (.clk_sys(clk_sys), .rst(rst), .insn_word(insn_word), .rf_rd_data(rf_rd_data),
    .pc_high_latch(pc_high_latch), .fetch_addr(fetch_addr), .rf_addr(rf_addr), .rf_wr_en(rf_wr_en),
    .rf_wr_data(rf_wr_data), .acc_out(acc_out), .zero_flag_out(zero_flag_out), .flush_out(flush_out));
  mcis_mem_model mem (.clk_sys(clk_sys), .fetch_addr(fetch_addr), .rf_addr(rf_addr), .rf_wr_en(rf_wr_en),
    .rf_wr_data(rf_wr_data), .insn_word(insn_word), .rf_rd_data(rf_rd_data));
  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [13:0] rop(input logic [5:0] op, input logic d, input logic [6:0] a);
    return {op, d, a};
  endfunction : rop
  task restart;
    rst = 1'b1;
    tick;
    tick;
    rst = 1'b0;
  endtask : restart
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Decrement-skip: zero result skips, flag kept, destinations
  task t_dec_skip;
    mem.regs[5] = 8'h01; mem.regs[6] = 8'h03;
    mem.prog[0] = {6'h38, 8'h00}; mem.prog[1] = rop(mcis_pkg::OP_DEC_SKIP, 1'b1, 7'h05);
    mem.prog[2] = {6'h38, 8'h0f}; mem.prog[3] = rop(mcis_pkg::OP_DEC_SKIP, 1'b0, 7'h06);
    restart;
    tick; chk(16'(zero_flag_out), 16'h0001);
    tick; chk(16'(mem.regs[5]), 16'h0000); chk(16'(flush_out), 16'h0001);
    chk(16'(zero_flag_out), 16'h0001);
    tick; chk(16'(acc_out), 16'h0000); chk(16'(flush_out), 16'h0000);
    tick; chk(16'(acc_out), 16'h0002); chk(16'(mem.regs[6]), 16'h0003);
    chk(16'(flush_out), 16'h0000); chk(16'(zero_flag_out), 16'h0001);
  endtask : t_dec_skip
  // Increment-skip wrap, plain increment sets and clears zero
  task t_inc;
    mem.regs[7] = 8'hff; mem.regs[8] = 8'hff; mem.regs[127] = 8'h10;
    mem.prog[0] = rop(mcis_pkg::OP_INC_SKIP, 1'b1, 7'h07); mem.prog[1] = {6'h38, 8'h80};
    mem.prog[2] = rop(mcis_pkg::OP_INC, 1'b0, 7'h08); mem.prog[3] = rop(mcis_pkg::OP_INC, 1'b1, 7'h7f);
    restart;
    tick; chk(16'(mem.regs[7]), 16'h0000); chk(16'(flush_out), 16'h0001);
    chk(16'(zero_flag_out), 16'h0000);
    tick; chk(16'(acc_out), 16'h0000);
    tick; chk(16'(zero_flag_out), 16'h0001); chk(16'(flush_out), 16'h0000);
    tick; chk(16'(mem.regs[127]), 16'h0011); chk(16'(zero_flag_out), 16'h0000);
    chk(16'(acc_out), 16'h0000);
  endtask : t_inc
  // OR with literal and with register
  task t_or;
    mem.regs[10] = 8'h05; mem.regs[11] = 8'h00;
    mem.prog[0] = {6'h38, 8'ha0}; mem.prog[1] = rop(mcis_pkg::OP_OR_REG, 1'b1, 7'h0a);
    mem.prog[2] = rop(mcis_pkg::OP_OR_REG, 1'b0, 7'h0a); mem.prog[3] = {6'h38, 8'h00};
    restart;
    tick; chk(16'(acc_out), 16'h00a0); chk(16'(zero_flag_out), 16'h0000);
    tick; chk(16'(mem.regs[10]), 16'h00a5); chk(16'(acc_out), 16'h00a0);
    tick; chk(16'(acc_out), 16'h00a5);
    tick; chk(16'(acc_out), 16'h00a5); chk(16'(zero_flag_out), 16'h0000);
  endtask : t_or
  // Jump builds page bits from the latch, costs two cycles
  task t_jump;
    pc_high_latch = 8'hf0;
    mem.prog[0] = {3'h5, 11'h123}; mem.prog[1] = {6'h38, 8'hff};
    mem.prog[13'h1123] = {6'h38, 8'h3c}; mem.prog[13'h1124] = {6'h38, 8'hc0};
    restart;
    tick; chk(16'(fetch_addr), 16'h1123); chk(16'(flush_out), 16'h0001);
    tick; chk(16'(fetch_addr), 16'h1123); chk(16'(acc_out), 16'h0000);
    chk(16'(flush_out), 16'h0000);
    tick; chk(16'(acc_out), 16'h003c); chk(16'(fetch_addr), 16'h1124);
  endtask : t_jump
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end
  // Main sequence
  initial begin
    n_errors = 0; num_checks = 0; rst = 1'b1; pc_high_latch = 8'h00;
    for (int i = 0; i < 8192; i++) mem.prog[i] = mcis_pkg::NOP_WORD;
    repeat (16) tick;
    t_dec_skip;
    t_inc;
    t_or;
    t_jump;
    print_verdict;
  end
endmodule : tb_mcu_core_insn_subset
`default_nettype wire
